// File: include/fault_sup_pkg.sv
// Constants, timing counts and state type for the LED driver fault supervisor.
// Assumes a single 100 MHz clock; all detector inputs arrive asynchronously.
// Summary of operation
// - Enable low beyond 32,750 cycles enters low-power shutdown and clears all fault records.
// - In shutdown, sinks stay off; operation resumes only after enable returns high.
// - Primary switch current limit turns boost off for that cycle only, no flag.
// - Secondary switch current limit latches everything off and sets the flag.
// - Input current at twice the limit latches everything off and sets the flag.
// - Input current between one and two times the limit flags; held beyond 10,000 cycles it latches everything off.
// - Secondary overvoltage on the switch node latches everything off with flag.
// - At startup a shorted sink holds off soft-start, disconnect on, no flag.
// - An open sink raises output until overvoltage, then drops unregulated strings.
// - Current-set overcurrent stops boost and sinks until cleared, no flag.
// - Frequency-set overcurrent turns all off with flag, restarts through soft-start.
// - Overvoltage sense stops boost only while tripped, no flag.
// - A sink above the LED-short threshold is removed alone, no flag.
// - Overtemperature turns all off and restarts automatically, no flag.
// - Undervoltage turns all off, clears latched faults, restarts automatically, no flag.
// - Startup masks selected detectors to avoid false triggering.
// - Disconnect-switch protections are unavailable when no disconnect switch is fitted.
// - Frequency-set pin low beyond 7 us stops boost, disconnect and sinks.
package fault_sup_pkg;
   localparam int CLK_FREQ_MHZ         = 100;
   localparam int FAST_SHDN_NS         = 7000;
   // Least time: round up to whole cycles
   localparam int FAST_SHDN_CYCLES     = (FAST_SHDN_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int SHUTDOWN_CYCLES      = 32750;
   localparam int LINEAR_FAULT_CYCLES  = 10000;
   localparam int SOFTSTART_CYCLES     = 1000;
   localparam int CHANNELS             = 2;
   // Thirteen single-bit inputs plus three per-channel vectors
   localparam int SYNC_W               = 13 + 3 * CHANNELS;

   typedef enum logic [1:0] {
      ST_SHDN,
      ST_CHECK,
      ST_SOFT,
      ST_RUN
   } state_t;
endpackage : fault_sup_pkg

// File: src/low_time_detect.sv
// Counts consecutive low cycles of a synchronised level.
// Assumes the level is already in the MCLK domain.
`timescale 1ns/1ps
module low_time_detect #(
   parameter int COUNT = 700
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic level,
   output logic      expired
);
   localparam int              W     = $clog2(COUNT + 2);
   localparam logic [W-1:0]    LIMIT = W'(COUNT + 1);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   // Expires only after strictly more than COUNT low cycles
   always_comb
   begin
      cnt_nxt = cnt_r;
      if (level)
         cnt_nxt = '0;
      else if (cnt_r != LIMIT)
         cnt_nxt = cnt_r + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         cnt_r <= '0;
      else
         cnt_r <= cnt_nxt;
   end

   assign expired = (cnt_r == LIMIT);

   restart_high_a : assert property (@(posedge clk) disable iff (rst)
      level |=> (cnt_r == '0) && !expired)
      else $error("low counter did not restart on high level");
endmodule : low_time_detect

// File: src/led_fault_supervisor.sv
// Fault supervision and shutdown control for a two-channel boost LED driver.
// Assumes analog detector outputs and pins are asynchronous levels, active high,
// except ENABLE_DIM and FREQ_SET_SYNC_PIN which are the raw pin levels.
`timescale 1ns/1ps
module led_fault_supervisor
   import fault_sup_pkg::*;
#(
   parameter int SHUTDOWN_CYCLES_P  = fault_sup_pkg::SHUTDOWN_CYCLES,
   parameter int LINEAR_CYCLES_P    = fault_sup_pkg::LINEAR_FAULT_CYCLES,
   parameter int SOFTSTART_CYCLES_P = fault_sup_pkg::SOFTSTART_CYCLES
) (
   input  wire logic                  MCLK,
   input  wire logic                  RESET,
   input  wire logic                  ENABLE_DIM,
   input  wire logic                  FREQ_SET_SYNC_PIN,
   input  wire logic                  PRIMARY_SWITCH_CURRENT_LIMIT,
   input  wire logic                  SECONDARY_SWITCH_CURRENT_LIMIT,
   input  wire logic                  INPUT_CURRENT_1X,
   input  wire logic                  INPUT_CURRENT_2X,
   input  wire logic                  SECONDARY_OVERVOLTAGE,
   input  wire logic                  OVERVOLTAGE_SENSE_INPUT,
   input  wire logic [fault_sup_pkg::CHANNELS-1:0] SINK_CHANNEL_SHORTED,
   input  wire logic [fault_sup_pkg::CHANNELS-1:0] SINK_CHANNEL_OPEN,
   input  wire logic [fault_sup_pkg::CHANNELS-1:0] LED_SHORT_DETECT,
   input  wire logic                  CURRENT_SET_OVER,
   input  wire logic                  FREQ_SET_OVER,
   input  wire logic                  OVER_TEMPERATURE,
   input  wire logic                  UNDERVOLTAGE_LOCKOUT,
   input  wire logic                  DISCONNECT_FITTED,
   output logic                       BOOST_EN,
   output logic                       DISCONNECT_EN,
   output logic [fault_sup_pkg::CHANNELS-1:0] SINK_EN,
   output logic                       VOUT_RAISE,
   output logic                       LOW_POWER,
   output logic                       FAULT_N_O,
   output logic                       FAULT_N_OE
);
   import fault_sup_pkg::*;

   localparam int LW = $clog2(LINEAR_CYCLES_P + 1);
   localparam int SS_W = $clog2(SOFTSTART_CYCLES_P + 1);
   localparam logic [LW-1:0]   LIN_LAST = LW'(LINEAR_CYCLES_P);
   localparam logic [SS_W-1:0] SS_LAST  = SS_W'(SOFTSTART_CYCLES_P);

   // Two-stage synchronisers for every asynchronous input
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   logic              en_s;
   logic              fss_s;
   logic              pri_s;
   logic              sec_s;
   logic              in1x_s;
   logic              in2x_s;
   logic              secov_s;
   logic              ovs_s;
   logic [CHANNELS-1:0] short_s;
   logic [CHANNELS-1:0] open_s;
   logic [CHANNELS-1:0] ledsc_s;
   logic              cset_s;
   logic              fset_s;
   logic              temp_s;
   logic              uv_s;
   logic              fitted_s;

   always_ff @(posedge MCLK)
   begin
      if (RESET)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= {ENABLE_DIM, FREQ_SET_SYNC_PIN, PRIMARY_SWITCH_CURRENT_LIMIT,
                     SECONDARY_SWITCH_CURRENT_LIMIT, INPUT_CURRENT_1X, INPUT_CURRENT_2X,
                     SECONDARY_OVERVOLTAGE, OVERVOLTAGE_SENSE_INPUT, SINK_CHANNEL_SHORTED,
                     SINK_CHANNEL_OPEN, LED_SHORT_DETECT, CURRENT_SET_OVER, FREQ_SET_OVER,
                     OVER_TEMPERATURE, UNDERVOLTAGE_LOCKOUT, DISCONNECT_FITTED};
         sync2_r <= sync1_r;
      end
   end

   assign {en_s, fss_s, pri_s, sec_s, in1x_s, in2x_s, secov_s, ovs_s, short_s,
           open_s, ledsc_s, cset_s, fset_s, temp_s, uv_s, fitted_s} = sync2_r;

   // Pin-low timers; reset on high so dimming pulses never shut down
   logic en_expired;
   logic fast_shdn;

   low_time_detect #(.COUNT(SHUTDOWN_CYCLES_P)) enable_low_shutdown_time (
      .clk     (MCLK),
      .rst     (RESET),
      .level   (en_s),
      .expired (en_expired)
   );

   low_time_detect #(.COUNT(FAST_SHDN_CYCLES)) fast_shutdown_time (
      .clk     (MCLK),
      .rst     (RESET),
      .level   (fss_s),
      .expired (fast_shdn)
   );

   // Control state
   state_t              state_r;
   state_t              state_nxt;
   logic                latched_r;
   logic                latched_nxt;
   logic [LW-1:0]       lin_cnt_r;
   logic [LW-1:0]       lin_cnt_nxt;
   logic [SS_W-1:0]     ss_cnt_r;
   logic [SS_W-1:0]     ss_cnt_nxt;
   logic                hunt_r;
   logic                hunt_nxt;
   logic [CHANNELS-1:0] open_off_r;
   logic [CHANNELS-1:0] open_off_nxt;
   logic                boost_r;
   logic                boost_nxt;
   logic                disc_r;
   logic                disc_nxt;
   logic [CHANNELS-1:0] sink_r;
   logic [CHANNELS-1:0] sink_nxt;
   logic                flag_r;
   logic                flag_nxt;

   logic in_shdn;
   logic active;
   logic startup_mask;
   logic in1x_eff;
   logic lin_expire;
   logic trip_now;
   logic hard_off;
   logic [CHANNELS-1:0] open_eff;

   assign in_shdn      = (state_r == ST_SHDN);
   assign active       = (state_r == ST_SOFT) || (state_r == ST_RUN);
   assign startup_mask = (state_r != ST_RUN);
   // Without a disconnect switch the input current sense means nothing
   assign in1x_eff     = in1x_s && fitted_s && !in2x_s && !in_shdn;
   assign lin_expire   = in1x_eff && (lin_cnt_r == LIN_LAST);
   assign trip_now     = sec_s || secov_s || (in2x_s && fitted_s)
                         || lin_expire;
   // Conditions that force boost, disconnect and sinks off
   assign hard_off     = latched_r || trip_now || fset_s || temp_s
                         || uv_s || fast_shdn;
   assign open_eff     = startup_mask ? '0 : (open_s & ~open_off_r);

   always_comb
   begin
      state_nxt    = state_r;
      latched_nxt  = latched_r | trip_now;
      lin_cnt_nxt  = '0;
      ss_cnt_nxt   = '0;
      hunt_nxt     = hunt_r;
      open_off_nxt = open_off_r;

      if (in1x_eff && !lin_expire)
         lin_cnt_nxt = lin_cnt_r + 1'b1;

      // Open sink: raise output until overvoltage, then drop open strings
      if (!active)
         hunt_nxt = 1'b0;
      else if (hunt_r && ovs_s)
      begin
         open_off_nxt = open_off_r | open_s;
         hunt_nxt     = 1'b0;
      end
      else if (|open_eff)
         hunt_nxt = 1'b1;

      case (state_r)
         ST_SHDN:
         begin
            if (en_s)
               state_nxt = ST_CHECK;
         end
         ST_CHECK:
         begin
            if (!hard_off && en_s && (short_s == '0))
               state_nxt = ST_SOFT;
         end
         ST_SOFT:
         begin
            ss_cnt_nxt = ss_cnt_r + 1'b1;
            if (hard_off)
               state_nxt = ST_CHECK;
            else if (ss_cnt_r == SS_LAST)
               state_nxt = ST_RUN;
         end
         ST_RUN:
         begin
            if (hard_off)
               state_nxt = ST_CHECK;
         end
         default:
            state_nxt = ST_SHDN;
      endcase

      // Undervoltage clears latched faults and open-string records
      // A trip in the same cycle still latches: the set wins
      if (uv_s)
      begin
         latched_nxt  = trip_now;
         open_off_nxt = '0;
      end

      // Enable held low too long: shutdown wins over everything
      if (en_expired)
      begin
         state_nxt    = ST_SHDN;
         latched_nxt  = 1'b0;
         open_off_nxt = '0;
         hunt_nxt     = 1'b0;
         lin_cnt_nxt  = '0;
      end
   end

   // Output decisions, registered so pins change only on MCLK
   always_comb
   begin
      boost_nxt = active && !hard_off && !pri_s && !ovs_s && !cset_s;
      disc_nxt  = !in_shdn && !hard_off && !en_expired;
      sink_nxt  = '0;
      if (active && !hard_off && !cset_s && !en_expired)
         sink_nxt = ~(ledsc_s | open_off_r);
      flag_nxt  = !en_expired && (latched_r || trip_now || fset_s
                  || in1x_eff);
   end

   always_ff @(posedge MCLK)
   begin
      if (RESET)
      begin
         state_r    <= ST_SHDN;
         latched_r  <= 1'b0;
         lin_cnt_r  <= '0;
         ss_cnt_r   <= '0;
         hunt_r     <= 1'b0;
         open_off_r <= '0;
         boost_r    <= 1'b0;
         disc_r     <= 1'b0;
         sink_r     <= '0;
         flag_r     <= 1'b0;
      end
      else
      begin
         state_r    <= state_nxt;
         latched_r  <= latched_nxt;
         lin_cnt_r  <= lin_cnt_nxt;
         ss_cnt_r   <= ss_cnt_nxt;
         hunt_r     <= hunt_nxt;
         open_off_r <= open_off_nxt;
         boost_r    <= boost_nxt;
         disc_r     <= disc_nxt;
         sink_r     <= sink_nxt;
         flag_r     <= flag_nxt;
      end
   end

   assign BOOST_EN      = boost_r;
   assign DISCONNECT_EN = disc_r;
   assign SINK_EN       = sink_r;
   assign VOUT_RAISE    = hunt_r;
   assign LOW_POWER     = in_shdn;
   // Open-drain fault pin: only ever pulls low
   assign FAULT_N_O     = 1'b0;
   assign FAULT_N_OE    = flag_r;

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RESET);

   shutdown_entry_a : assert property (en_expired |=> in_shdn && !latched_r)
      else $error("enable-low timeout did not shut down and clear");

   shutdown_sinks_a : assert property (en_expired ##1 in_shdn |=> SINK_EN == '0)
      else $error("sinks active in shutdown");

   primary_limit_a : assert property (pri_s |=> !BOOST_EN)
      else $error("boost not off on primary current limit");

   secondary_limit_a : assert property (sec_s && !en_expired |=>
      latched_r && !BOOST_EN && !DISCONNECT_EN && SINK_EN == '0 && FAULT_N_OE)
      else $error("secondary current limit did not latch off");

   input_double_a : assert property (in2x_s && fitted_s && !en_expired && !uv_s
      |=> latched_r && !DISCONNECT_EN)
      else $error("double input current did not latch");

   linear_flag_a : assert property (in1x_eff && !en_expired |=> FAULT_N_OE)
      else $error("fault flag missing in linear mode");

   switch_overvolt_a : assert property (secov_s && !en_expired && !uv_s
      |=> latched_r && !BOOST_EN && SINK_EN == '0)
      else $error("secondary overvoltage did not latch off");

   start_short_a : assert property (state_r == ST_CHECK && short_s != '0 && !en_expired
      |=> state_r == ST_CHECK && !BOOST_EN && SINK_EN == '0)
      else $error("soft-start began with a shorted sink");

   overvolt_stop_a : assert property (ovs_s |=> !BOOST_EN)
      else $error("boost switched during overvoltage");

   current_set_a : assert property (cset_s |=> !BOOST_EN && SINK_EN == '0)
      else $error("boost or sinks active on current-set overcurrent");

   led_short_a : assert property (ledsc_s[0] |=> !SINK_EN[0])
      else $error("shorted string kept sinking");

   over_temp_a : assert property (temp_s |=>
      !BOOST_EN && !DISCONNECT_EN && SINK_EN == '0 && state_r != ST_RUN)
      else $error("overtemperature did not turn all off");

   undervolt_clear_a : assert property (uv_s && !trip_now |=> !latched_r)
      else $error("undervoltage did not clear latched faults");

   fast_shutdown_a : assert property (fast_shdn |=>
      !BOOST_EN && !DISCONNECT_EN && SINK_EN == '0)
      else $error("fast shutdown did not stop outputs");
endmodule : led_fault_supervisor

// File: dv/host_model.sv
// Host controller model: drives the enable/dimming and freq-set/sync pins.
// Assumes one MCLK; pins change by non-blocking assignment at a rising edge.
`timescale 1ns/1ps
module host_model
(
   input  wire logic MCLK,
   output logic      ENABLE_DIM,
   output logic      FREQ_SET_SYNC_PIN
);
   initial
   begin
      ENABLE_DIM        = 1'b0;
      FREQ_SET_SYNC_PIN = 1'b1;
   end

   // Low beyond the shutdown count powers down; short lows are dimming
   task automatic set_en(input logic v);
      @(posedge MCLK);
      ENABLE_DIM <= v;
   endtask : set_en

   // Drives the freq-set/sync pin to v at the next rising edge
   task automatic set_sync(input logic v);
      @(posedge MCLK);
      FREQ_SET_SYNC_PIN <= v;
   endtask : set_sync
endmodule : host_model

// File: dv/testbench.sv
// Self-checking bench for the LED fault supervisor with shortened counts.
// Assumes host_model drives the two host pins; detectors are bench levels.
`timescale 1ns/1ps
module testbench;
   import fault_sup_pkg::*;
   localparam int SHD = 40;
   logic        mclk;
   logic        reset;
   logic [15:0] det;
   logic        fit;
   logic        en_pin;
   logic        sync_pin;
   logic        boost;
   logic        disc;
   logic [1:0]  sink;
   logic        raise;
   logic        low_pwr;
   logic        flag_o;
   logic        flag_oe;
   logic [6:0]  seen;
   int          error_cnt;
   int          checks_done;
   int          i;
   logic [15:0] tab_det [7];
   logic [6:0]  tab_exp [7];

   assign seen = {low_pwr, boost, disc, sink, flag_oe, raise};

   host_model host (.MCLK(mclk), .ENABLE_DIM(en_pin), .FREQ_SET_SYNC_PIN(sync_pin));

   led_fault_supervisor #(.SHUTDOWN_CYCLES_P(SHD), .LINEAR_CYCLES_P(20),
      .SOFTSTART_CYCLES_P(8)) uut (
      .MCLK(mclk), .RESET(reset), .ENABLE_DIM(en_pin), .FREQ_SET_SYNC_PIN(sync_pin),
      .PRIMARY_SWITCH_CURRENT_LIMIT(det[0]), .SECONDARY_SWITCH_CURRENT_LIMIT(det[1]),
      .INPUT_CURRENT_1X(det[2]), .INPUT_CURRENT_2X(det[3]), .SECONDARY_OVERVOLTAGE(det[4]),
      .OVERVOLTAGE_SENSE_INPUT(det[5]), .CURRENT_SET_OVER(det[6]), .FREQ_SET_OVER(det[7]),
      .OVER_TEMPERATURE(det[8]), .UNDERVOLTAGE_LOCKOUT(det[9]),
      .LED_SHORT_DETECT({det[13], det[10]}), .SINK_CHANNEL_SHORTED({det[14], det[11]}),
      .SINK_CHANNEL_OPEN({det[12], det[15]}), .DISCONNECT_FITTED(fit),
      .BOOST_EN(boost), .DISCONNECT_EN(disc), .SINK_EN(sink), .VOUT_RAISE(raise),
      .LOW_POWER(low_pwr), .FAULT_N_O(flag_o), .FAULT_N_OE(flag_oe));

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc

   task automatic compare(input logic [6:0] got, input logic [6:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: outputs %h, expected %h", $time, got, exp);
      end
   endtask : compare

   // Sample one ns after the edge so registered outputs have settled
   task automatic chk(input logic [6:0] exp);
      #1;
      compare(seen, exp);
   endtask : chk

   task automatic drive(input logic [15:0] v);
      @(posedge mclk);
      det <= v;
   endtask : drive

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   initial
   begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      report_and_stop();
   end

   // Order: lp, boost, disconnect, sinks[1:0], flag, raise
   initial
   begin
      reset = 1'b1;
      det = 16'h0000;
      fit = 1'b1;
      error_cnt = 0;
      checks_done = 0;
      tab_det = '{16'h0001, 16'h0020, 16'h0400, 16'h0040, 16'h0100, 16'h0080, 16'h0004};
      tab_exp = '{7'h1C, 7'h1C, 7'h38, 7'h10, 7'h00, 7'h02, 7'h3E};
      cyc(4);
      chk(7'h40);
      @(posedge mclk);
      reset <= 1'b0;
      host.set_en(1'b1);
      cyc(20);
      chk(7'h3C);
      compare({6'h00, flag_o}, 7'h00);
      for (i = 0; i < 7; i++)
      begin
         drive(tab_det[i]);
         cyc(6);
         chk(tab_exp[i]);
         drive(16'h0000);
         cyc(20);
         chk(7'h3C);
      end
      for (i = 1; i < 5; i++)
      begin
         if (i == 2)
            continue;
         drive(16'h0001 << i);
         cyc(6);
         drive(16'h0000);
         cyc(6);
         chk(7'h02);
         host.set_en(1'b0);
         cyc(SHD - 10);
         host.set_en(1'b1);
         host.set_en(1'b0);
         cyc(SHD - 10);
         chk(7'h02);
         cyc(15);
         chk(7'h40);
         host.set_en(1'b1);
         cyc(20);
         chk(7'h3C);
      end
      // Linear-mode time runs out and latches; undervoltage clears it
      drive(16'h0004);
      cyc(30);
      drive(16'h0000);
      cyc(4);
      chk(7'h02);
      drive(16'h0200);
      cyc(6);
      chk(7'h00);
      drive(16'h0000);
      cyc(20);
      chk(7'h3C);
      drive(16'h0008);
      fit <= 1'b0;
      cyc(6);
      chk(7'h3C);
      drive(16'h0000);
      fit <= 1'b1;
      host.set_sync(1'b0);
      cyc(705);
      chk(7'h00);
      host.set_sync(1'b1);
      cyc(20);
      chk(7'h3C);
      drive(16'h1000);
      cyc(6);
      chk(7'h3D);
      drive(16'h1020);
      cyc(6);
      drive(16'h0000);
      cyc(6);
      chk(7'h34);
      // Short present at power-up holds soft-start off
      drive(16'h0800);
      host.set_en(1'b0);
      cyc(SHD + 8);
      chk(7'h40);
      host.set_en(1'b1);
      cyc(20);
      chk(7'h10);
      drive(16'h0000);
      cyc(20);
      chk(7'h3C);
      // Other channel of each sink detector; undervoltage clears the open record
      drive(16'h2000);
      cyc(6);
      chk(7'h34);
      drive(16'h8000);
      cyc(6);
      chk(7'h3D);
      drive(16'h8020);
      cyc(6);
      drive(16'h0000);
      cyc(6);
      chk(7'h38);
      drive(16'h4200);
      cyc(6);
      chk(7'h00);
      drive(16'h4000);
      cyc(20);
      chk(7'h10);
      drive(16'h0000);
      cyc(20);
      chk(7'h3C);
      report_and_stop();
   end
endmodule : testbench
